/* File: logic/dbs_sequencer.sv */
// Purpose: Dynamic bus sizing sequencer with request FIFO
// Assumes: Bus acknowledges sampled synchronously, one cycle per bus cycle
// Notes: Byte operands and address space decode are not handled
`include "dbs_cfg.svh"

// =====================================
// Request FIFO
module dbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `DBS_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic push, pop;
   always_comb begin
      in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
      out_valid_o = wp_r != rp_r;
      out_data_o = mem_r[rp_r[AW-1:0]];
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data_i;
      end
   end
   fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wp_r - rp_r) <= (AW+1)'(DEPTH)) else $error("FIFO count over depth");
   fifo_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !in_ready_o |-> out_valid_o)
      else $error("Full FIFO shows no data");
   fifo_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
      else $error("Pending FIFO head changed");
endmodule // dbs_fifo

// =====================================
// Sequencer
module dbs_sequencer #(
   parameter int FIFO_DEPTH = `DBS_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire dbs_pkg::dbs_req_type req_i,
   output logic bus_active_o,
   output logic [`DBS_ADDR_W-1:0] addr_o,
   output logic size_code_hi_o,
   output logic size_code_lo_o,
   output logic [`DBS_FC_W-1:0] access_space_code_o,
   output logic read_write_strobe_o,
   output logic [15:0] data_o,
   output logic data_oe_o,
   input wire logic [15:0] data_i,
   input wire logic ack_port8_i,
   input wire logic ack_port16_i,
   output logic rd_valid_o,
   output logic [31:0] rd_data_o
);
   typedef enum logic [0:0] {DBS_IDLE, DBS_RUN} dbs_state_type;
   dbs_state_type st_r, st_nxt;
   dbs_pkg::dbs_req_type cur_r, cur_nxt, fifo_out;
   logic [2:0] rem_r, rem_nxt;
   logic [2:0] half_r, half_nxt;
   logic [`DBS_ADDR_W-1:0] addr_r, addr_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic fifo_valid, fifo_take, ack;
   logic [2:0] step, done_bytes;
   logic [1:0] sz;
   logic [7:0] b_first, b_second;

   initial begin
      if (FIFO_DEPTH < 2) $error("Request FIFO depth too small");
   end

   dbs_fifo #(.WIDTH(dbs_pkg::REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(req_valid_i),
      .in_ready_o(req_ready_o),
      .in_data_i(req_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_take),
      .out_data_o(fifo_out)
   );

   always_comb begin
      ack = ack_port8_i || ack_port16_i;
      // Bytes already moved, and the two next bytes of the operand
      done_bytes = (cur_r.is_long ? `DBS_BYTES_LONG : `DBS_BYTES_WORD) - rem_r;
      b_first = cur_r.data[31 - 8*done_bytes[1:0] -: 8];
      b_second = cur_r.data[23 - 8*done_bytes[1:0] -: 8];
      // Remaining count within the current half; misaligned long uses word pieces
      case (half_r)
         `DBS_BYTES_LONG: sz = `DBS_SIZE_LONG;
         `DBS_BYTES_THREE: sz = `DBS_SIZE_THREE;
         `DBS_BYTES_WORD: sz = `DBS_SIZE_WORD;
         default: sz = `DBS_SIZE_BYTE;
      endcase
      // Aligned long on a 16-bit port moves a word on each of its two acks
      // Port 8 moves one byte; port 16 moves two when aligned with at least two bytes left in the half, else one
      if (ack_port16_i && !addr_r[0] && half_r >= `DBS_BYTES_WORD) begin
         step = `DBS_STEP_PORT16;
      end else begin
         step = `DBS_STEP_PORT8;
      end
      // Write lane steering
      if (addr_r[0] && half_r == `DBS_BYTES_WORD && done_bytes[0] == 1'b0 && cur_r.is_long == 1'b0) begin
         data_o = {b_first, b_first};
      end else if (addr_r[0]) begin
         data_o = {b_first, b_first};
      end else if (half_r == `DBS_BYTES_ONE) begin
         data_o = {b_first, b_first};
      end else begin
         data_o = {b_first, b_second};
      end
      st_nxt = st_r;
      cur_nxt = cur_r;
      rem_nxt = rem_r;
      half_nxt = half_r;
      addr_nxt = addr_r;
      rd_nxt = rd_r;
      rd_valid_nxt = 1'b0;
      fifo_take = 1'b0;
      case (st_r)
         DBS_IDLE: begin
            if (fifo_valid) begin
               fifo_take = 1'b1;
               cur_nxt = fifo_out;
               addr_nxt = fifo_out.addr;
               rem_nxt = fifo_out.is_long ? `DBS_BYTES_LONG : `DBS_BYTES_WORD;
               half_nxt = (fifo_out.is_long && !fifo_out.addr[0]) ? `DBS_BYTES_LONG : `DBS_BYTES_WORD;
               rd_nxt = '0;
               st_nxt = DBS_RUN;
            end
         end
         DBS_RUN: begin
            if (ack) begin
               // Read capture by lane and acknowledge
               if (step == `DBS_STEP_PORT16) begin
                  rd_nxt[31 - 8*done_bytes[1:0] -: 16] = data_i;
               end else if (ack_port16_i && addr_r[0]) begin
                  rd_nxt[31 - 8*done_bytes[1:0] -: 8] = data_i[`DBS_LANE_LO];
               end else begin
                  rd_nxt[31 - 8*done_bytes[1:0] -: 8] = data_i[`DBS_LANE_HI];
               end
               rem_nxt = rem_r - step;
               addr_nxt = addr_r + `DBS_ADDR_W'(step);
               half_nxt = (half_r == step) ? `DBS_BYTES_WORD : half_r - step;
               if (rem_r == step) begin
                  st_nxt = DBS_IDLE;
                  rd_valid_nxt = !cur_r.write;
               end
            end
         end
         default: st_nxt = DBS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= DBS_IDLE;
         cur_r <= '0;
         rem_r <= '0;
         half_r <= '0;
         addr_r <= '0;
         rd_r <= '0;
         rd_valid_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         rem_r <= rem_nxt;
         half_r <= half_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   always_comb begin
      bus_active_o = st_r == DBS_RUN;
      addr_o = addr_r;
      size_code_hi_o = sz[1];
      size_code_lo_o = sz[0];
      access_space_code_o = cur_r.space;
      read_write_strobe_o = !cur_r.write;
      data_oe_o = bus_active_o && cur_r.write;
      rd_valid_o = rd_valid_r;
      rd_data_o = rd_r;
   end

   // =====================================
   // Checks
   long_size_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(bus_active_o) && cur_r.is_long && !addr_r[0] |-> {size_code_hi_o, size_code_lo_o} == 2'h0)
      else $error("Aligned long must start with long size");
   mis_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(bus_active_o) && addr_r[0] |-> {size_code_hi_o, size_code_lo_o} == `DBS_SIZE_WORD)
      else $error("Odd start must show word size");
   step_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port8_i && !ack_port16_i |=> addr_r == $past(addr_r) + 24'h1)
      else $error("Byte ack must bump address by one");
   long16_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port16_i && !addr_r[0] && cur_r.is_long && rem_r == 3'h4 |=>
      bus_active_o && addr_r == $past(addr_r) + 24'h2 && {size_code_hi_o, size_code_lo_o} == 2'h2)
      else $error("Long on 16-bit port second cycle wrong");
   word16_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port16_i && !addr_r[0] && !cur_r.is_long |=> !bus_active_o ##0 rd_valid_o == !$past(cur_r.write))
      else $error("Aligned word on 16-bit port not single cycle");
   mis_rep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_oe_o && addr_r[0] |-> data_o[15:8] == data_o[7:0])
      else $error("Odd write must replicate byte");
   strobe_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o |-> read_write_strobe_o == !cur_r.write)
      else $error("Direction strobe wrong");
   end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack && rem_r == 3'h1 |=> !bus_active_o)
      else $error("Transfer did not end at zero");

   // =====================================
   // Bus hold and lane drive checks
   hold_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && !ack |=> $stable(addr_o))
      else $error("Address moved without ack");
   hold_size_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && !ack |=> $stable({size_code_hi_o, size_code_lo_o}))
      else $error("Size code moved without ack");
   hold_space_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && !ack |=> $stable(access_space_code_o))
      else $error("Space code moved in a cycle");
   hold_wdata_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_oe_o && !ack |=> $stable(data_o))
      else $error("Write lanes moved without ack");
   oe_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !bus_active_o |-> !data_oe_o)
      else $error("Lanes driven while idle");
   oe_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && !read_write_strobe_o |-> data_oe_o)
      else $error("Write cycle without lane drive");

   // =====================================
   // Start, size and step checks
   start_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(bus_active_o) |-> addr_o == cur_r.addr)
      else $error("First cycle not at request address");
   start_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(bus_active_o) && !cur_r.is_long |-> {size_code_hi_o, size_code_lo_o} == `DBS_SIZE_WORD)
      else $error("Word must start with word size");
   three_long_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && {size_code_hi_o, size_code_lo_o} == `DBS_SIZE_THREE |-> cur_r.is_long && !cur_r.addr[0])
      else $error("Three byte size outside aligned long");
   long8_three_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port8_i && !ack_port16_i && cur_r.is_long && !cur_r.addr[0] && rem_r == `DBS_BYTES_LONG
      |=> {size_code_hi_o, size_code_lo_o} == `DBS_SIZE_THREE)
      else $error("Second long cycle not three bytes");
   long8_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port8_i && !ack_port16_i && cur_r.is_long && !cur_r.addr[0] && rem_r == `DBS_BYTES_THREE
      |=> {size_code_hi_o, size_code_lo_o} == `DBS_SIZE_WORD)
      else $error("Third long cycle not word size");
   long8_byte_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port8_i && !ack_port16_i && cur_r.is_long && !cur_r.addr[0] && rem_r == `DBS_BYTES_WORD
      |=> {size_code_hi_o, size_code_lo_o} == `DBS_SIZE_BYTE)
      else $error("Last long cycle not byte size");
   rem_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack && rem_r > `DBS_BYTES_WORD |=> bus_active_o)
      else $error("Transfer ended with bytes left");
   addr16_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port16_i && addr_r[0] |=> addr_o == $past(addr_o) + 24'h1)
      else $error("Odd 16-bit ack must bump address by one");

   // =====================================
   // Lane checks
   lane_hi_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port8_i && !ack_port16_i && read_write_strobe_o
      |=> rd_r[31 - 8*$past(done_bytes[1:0]) -: 8] == $past(data_i[`DBS_LANE_HI]))
      else $error("Byte port read not from upper lane");
   lane_lo_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port16_i && addr_r[0] && read_write_strobe_o
      |=> rd_r[31 - 8*$past(done_bytes[1:0]) -: 8] == $past(data_i[`DBS_LANE_LO]))
      else $error("Odd 16-bit read not from lower lane");
   lane_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      bus_active_o && ack_port16_i && !addr_r[0] && half_r >= `DBS_BYTES_WORD && read_write_strobe_o
      |=> rd_r[31 - 8*$past(done_bytes[1:0]) -: 16] == $past(data_i))
      else $error("Aligned 16-bit read not whole word");
   wr_pair_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_oe_o && !addr_r[0] && half_r >= `DBS_BYTES_WORD |-> data_o == cur_r.data[31 - 8*done_bytes[1:0] -: 16])
      else $error("Aligned write lanes wrong");
   wr_last_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      data_oe_o && half_r == `DBS_BYTES_ONE |-> data_o[`DBS_LANE_HI] == cur_r.data[31 - 8*done_bytes[1:0] -: 8])
      else $error("Last byte not on upper lane");

   // =====================================
   // Read completion checks
   rd_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_valid_o |=> !rd_valid_o)
      else $error("Read done longer than one cycle");
   rd_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_valid_o |-> !bus_active_o && read_write_strobe_o)
      else $error("Read done outside a finished read");
endmodule // dbs_sequencer

/* File: logic/dbs_cfg.svh */
// Purpose: Constants for the dynamic bus sizing sequencer
// Assumes: Included by the package and the design file
// Notes: Definitions only
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH
`define DBS_SIZE_BYTE 2'h1
`define DBS_SIZE_WORD 2'h2
`define DBS_SIZE_THREE 2'h3
`define DBS_SIZE_LONG 2'h0
`define DBS_ADDR_W 24
`define DBS_FC_W 3
`define DBS_FIFO_DEPTH 8
`define DBS_BYTES_LONG 3'h4
`define DBS_BYTES_THREE 3'h3
`define DBS_BYTES_WORD 3'h2
`define DBS_BYTES_ONE 3'h1
`define DBS_STEP_PORT16 3'h2
`define DBS_STEP_PORT8 3'h1
`define DBS_LANE_HI 15:8
`define DBS_LANE_LO 7:0
`endif

/* File: logic/dbs_pkg.sv */
// Purpose: Types for the dynamic bus sizing sequencer
// Assumes: dbs_cfg.svh gives widths
// Notes: Requests travel as one struct
`include "dbs_cfg.svh"
package dbs_pkg;
   typedef struct packed {
      logic is_long;
      logic write;
      logic [`DBS_FC_W-1:0] space;
      logic [`DBS_ADDR_W-1:0] addr;
      logic [31:0] data;
   } dbs_req_type;
   localparam int REQ_W = $bits(dbs_req_type);
endpackage

/* File: tb/dbs_port_model.sv */
// Purpose: Far-side 8 or 16 bit port model
// Assumes: One-cycle ack pulses, delay_i wait cycles per bus cycle
// Notes: 16-byte memory, address wraps
module dbs_port_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic port16_i,
   input wire logic [2:0] delay_i,
   input wire logic active_i,
   input wire logic [3:0] a_i,
   input wire logic [1:0] size_i,
   input wire logic rd_i,
   input wire logic oe_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] data_o,
   output logic ack8_o,
   output logic ack16_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [16];
   logic [2:0] cnt;
   // =====================================
   // Responder
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) mem[i] <= 8'ha0 | 8'(i);
         cnt <= 3'h0;
         ack8_o <= 1'b0;
         ack16_o <= 1'b0;
         data_o <= 16'h5a5a;
      end else if (ack8_o || ack16_o || !active_i || cnt != delay_i) begin
         ack8_o <= 1'b0;
         ack16_o <= 1'b0;
         cnt <= (ack8_o || ack16_o || !active_i) ? 3'h0 : cnt + 3'h1;
         data_o <= ~data_o;
      end else begin
         ack8_o <= !port16_i;
         ack16_o <= port16_i;
         if (!port16_i || !a_i[0]) data_o <= {mem[a_i], port16_i ? mem[a_i + 4'h1] : ~mem[a_i]};
         else data_o <= {~mem[a_i], mem[a_i]};
         if (!rd_i && oe_i) begin
            if (!port16_i || (!a_i[0] && size_i == 2'h1)) mem[a_i] <= wdata_i[15:8];
            else if (a_i[0]) mem[a_i] <= wdata_i[7:0];
            else begin
               mem[a_i] <= wdata_i[15:8];
               mem[a_i + 4'h1] <= wdata_i[7:0];
            end
         end
      end
   end
endmodule // dbs_port_model

/* File: tb/dbs_sequencer_bench.sv */
// Purpose: Self-checking bench for the bus sizing sequencer
// Assumes: Inputs driven at falling edge
// Notes: Reads use bytes 0 to 4, writes bytes 8 to 12
module dbs_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_n_i, req_valid_i, req_ready_o, bus_active_o, hi, lo, rw, oe, ack8, ack16, rd_valid_o, port16, exp_rd;
   dbs_pkg::dbs_req_type req;
   logic [23:0] addr;
   logic [2:0] space, dly;
   logic [15:0] wdata, rdata;
   logic [31:0] rd_data_o, rd_last;
   logic [5:0] seen [$];
   int n_fail, n_tests, rd_seen;
   dbs_sequencer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_i(req), .bus_active_o(bus_active_o), .addr_o(addr), .size_code_hi_o(hi), .size_code_lo_o(lo),
      .access_space_code_o(space), .read_write_strobe_o(rw), .data_o(wdata), .data_oe_o(oe), .data_i(rdata),
      .ack_port8_i(ack8), .ack_port16_i(ack16), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
   dbs_port_model part_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .port16_i(port16), .delay_i(dly), .active_i(bus_active_o),
      .a_i(addr[3:0]), .size_i({hi, lo}), .rd_i(rw), .oe_i(oe), .wdata_i(wdata), .data_o(rdata), .ack8_o(ack8),
      .ack16_o(ack16));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // =====================================
   // Bus monitor
   always @(negedge clk_i) begin
      if (rd_valid_o === 1'b1) begin
         rd_seen++;
         rd_last = rd_data_o;
      end
      if (bus_active_o && (ack8 || ack16)) begin
         seen.push_back({hi, lo, addr[3:0]});
         check("strobe", 32'(exp_rd), 32'(rw));
         check("space", 32'h5, 32'(space));
      end
   end
   // =====================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic timeout;
      check("timeout", 32'h0, 32'h1);
      tally_and_finish();
   endtask
   task automatic offer(input logic lg, input logic wr, input logic [23:0] a);
      int k;
      req = '{lg, wr, 3'h5, a, 32'hc1d2e3f4 ^ {a[7:0], 24'h0}};
      req_valid_i = 1'b1;
      k = 0;
      while (req_ready_o !== 1'b1) begin
         @(negedge clk_i);
         k++;
         if (k > 50) timeout();
      end
      @(negedge clk_i);
      req_valid_i = 1'b0;
   endtask
   task automatic run_op(input logic lg, input logic wr, input logic p16, input logic [23:0] a, input logic [2:0] d);
      logic [5:0] ex [$];
      logic [23:0] b;
      logic [31:0] v, m;
      int n, rem, st, k, n0;
      port16 = p16;
      dly = d;
      exp_rd = !wr;
      n = lg ? 4 : 2;
      rem = (lg && a[0]) ? 2 : n;
      b = a;
      for (int left = n; left > 0; left -= st) begin
         ex.push_back({rem == 4 ? 2'h0 : 2'(rem), b[3:0]});
         st = (p16 && !b[0] && rem > 1) ? 2 : 1;
         b += 24'(st);
         rem = (rem == st) ? left - st : rem - st;
      end
      seen.delete();
      n0 = rd_seen;
      offer(lg, wr, a);
      k = 0;
      while (seen.size() < ex.size() || bus_active_o !== 1'b0) begin
         @(negedge clk_i);
         k++;
         if (k > 300) timeout();
      end
      @(negedge clk_i);
      check("cycles", 32'(ex.size()), 32'(seen.size()));
      foreach (ex[i]) check("size_addr", 32'(ex[i]), 32'(seen[i]));
      v = req.data;
      m = lg ? 32'hffffffff : 32'hffff0000;
      if (wr) for (int i = 0; i < n; i++) check("wbyte", 32'(v[31-8*i -: 8]), 32'(part_u.mem[4'(a + 24'(i))]));
      else begin
         for (int i = 0; i < 4; i++) v[31-8*i -: 8] = {4'ha, 4'(a + 24'(i))};
         check("reads", 32'(n0 + 1), 32'(rd_seen));
         check("rdata", v & m, rd_last & m);
      end
   endtask
   task automatic sc_port(input logic p16);
      run_op(1'b0, 1'b0, p16, 24'h0, 3'h0);
      run_op(1'b0, 1'b0, p16, 24'h1, 3'h2);
      run_op(1'b0, 1'b1, p16, 24'h8, 3'h0);
      run_op(1'b0, 1'b1, p16, 24'h9, 3'h1);
      run_op(1'b1, 1'b0, p16, 24'h0, 3'h0);
      run_op(1'b1, 1'b0, p16, 24'h1, 3'h0);
      run_op(1'b1, 1'b1, p16, 24'h8, 3'h2);
      run_op(1'b1, 1'b1, p16, 24'h9, 3'h0);
   endtask
   task automatic sc_fifo_fill;
      int acc, k, n0;
      logic full;
      acc = 0;
      k = 0;
      full = 1'b0;
      n0 = rd_seen;
      port16 = 1'b0;
      dly = 3'h3;
      exp_rd = 1'b1;
      req = '{1'b1, 1'b0, 3'h5, 24'h0, 32'h0};
      req_valid_i = 1'b1;
      while (acc < 10) begin
         if (req_ready_o === 1'b1) acc++;
         else full = 1'b1;
         @(negedge clk_i);
         k++;
         if (k > 400) timeout();
      end
      req_valid_i = 1'b0;
      while (rd_seen - n0 < 10) begin
         @(negedge clk_i);
         k++;
         if (k > 1200) timeout();
      end
      check("refused", 32'h1, 32'(full));
      check("served", 32'ha, 32'(rd_seen - n0));
      check("rdata", 32'ha0a1a2a3, rd_last);
   endtask
   initial begin
      n_fail = 0;
      n_tests = 0;
      rd_seen = 0;
      rst_n_i = 1'b0;
      req_valid_i = 1'b0;
      req = '0;
      port16 = 1'b0;
      dly = 3'h0;
      exp_rd = 1'b1;
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      sc_port(1'b0);
      sc_port(1'b1);
      sc_fifo_fill();
      tally_and_finish();
   end
endmodule // dbs_sequencer_bench
